// *** hw/net_endpoint.v ***
// network access endpoint: joins user logic to the packet network with a
// send path, a receive path, an upstream merge and an ahb-lite settings port.
// assumes all neighbours run on clk_in; offers hold stable until taken.
`timescale 1ns/1ps
`include "net_endpoint_map.vh"

module net_endpoint #(
	parameter DATA_W = 293,
	parameter ID_W = 4,
	parameter LEVEL_W = 8
) (
	input wire clk_in,
	input wire sys_rst_in,
	input wire intf_rst_n_in,
	input wire hsel_in,
	input wire [31:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	output wire [31:0] hrdata_out,
	output wire hreadyout_out,
	output wire hresp_out,
	output wire fabric_rst_n_out,
	input wire send_offer_in,
	output wire send_accept_out,
	input wire [ID_W-1:0] send_dest_in,
	input wire send_sop_in,
	input wire send_eop_in,
	input wire [DATA_W-1:0] send_data_in,
	output wire recv_offer_out,
	input wire recv_accept_in,
	output wire [ID_W-1:0] recv_src_out,
	output wire recv_sop_out,
	output wire recv_eop_out,
	output wire [DATA_W-1:0] recv_data_out,
	input wire up_offer_in,
	output wire up_accept_out,
	input wire [ID_W-1:0] up_dest_in,
	input wire up_sop_in,
	input wire up_eop_in,
	input wire [DATA_W-1:0] up_data_in,
	output wire dn_offer_out,
	input wire dn_accept_in,
	output wire [ID_W-1:0] dn_dest_out,
	output wire dn_sop_out,
	output wire dn_eop_out,
	output wire [DATA_W-1:0] dn_data_out,
	input wire net_offer_in,
	output wire net_accept_out,
	input wire [ID_W-1:0] net_src_in,
	input wire net_sop_in,
	input wire net_eop_in,
	input wire [DATA_W-1:0] net_data_in,
	input wire [LEVEL_W-1:0] send_level_in,
	input wire [LEVEL_W-1:0] recv_level_in,
	output wire [3:0] send_at_mark_out,
	output wire [3:0] recv_at_mark_out
);

// ***************************************
// settings registers
// ***************************************
reg send_en_ff; // send path on
reg recv_en_ff; // receive path on
reg north_ff; // selects which pattern arbitrates
reg [3:0] row_ff; // row placement
reg [3:0] col_ff; // column placement
reg [3:0] send_rate_ff;
reg [1:0] send_mac_select_ff;
reg [4:0] send_chan_ff;
reg [3:0] recv_rate_ff;
reg [1:0] recv_mac_select_ff;
reg [4:0] recv_chan_ff;
reg [31:0] send_mark_ff; // send fifo level marks
reg [31:0] recv_mark_ff; // receive fifo level marks
reg [31:0] southbound_priority_pattern_ff;
reg [31:0] northbound_priority_pattern_ff;
reg [3:0] send_at_mark_ff;
reg [3:0] recv_at_mark_ff;
reg fabric_rst_n_ff;

// ***************************************
// bus slave state
// ***************************************
reg wr_pend_ff; // write data phase pending
reg rd_pend_ff; // read data phase pending
reg [7:0] wr_addr_ff; // latched write offset
reg [7:0] rd_addr_ff; // latched read offset
reg [31:0] hrdata_ff;
reg hreadyout_ff;
reg hresp_ff;
reg [31:0] rd_word; // read mux result

// ***************************************
// path registers
// ***************************************
reg send_accept_ff;
reg up_accept_ff;
reg dn_valid_ff;
reg [ID_W-1:0] dn_dest_ff;
reg dn_sop_ff;
reg dn_eop_ff;
reg [DATA_W-1:0] dn_data_ff;
reg net_accept_ff;
reg recv_valid_ff;
reg [ID_W-1:0] recv_src_ff;
reg recv_sop_ff;
reg recv_eop_ff;
reg [DATA_W-1:0] recv_data_ff;

// handshakes taken on this edge
wire send_take = send_offer_in & send_accept_ff;
wire up_take = up_offer_in & up_accept_ff;
wire net_take = net_offer_in & net_accept_ff;
wire recv_take = recv_valid_ff & recv_accept_in;

// slot state for next cycle
wire nxt_dn_valid = send_take | up_take | (dn_valid_ff & ~dn_accept_in);
wire nxt_recv_valid = net_take | (recv_valid_ff & ~recv_take);

// offers still waiting after this edge
wire send_wait = send_offer_in & ~send_take & send_en_ff;
wire up_wait = up_offer_in & ~up_take;
wire contend = send_wait & up_wait & ~nxt_dn_valid;

// active pattern bit decides contention
wire [31:0] act_prio = north_ff ? northbound_priority_pattern_ff : southbound_priority_pattern_ff;
wire local_wins = act_prio[0];

// grant: only one side sees accept in a cycle, so two takes never collide
wire grant_local = contend ? local_wins : ~up_wait;

// pass-through channels leave the fifo marks unused
wire send_buffered = send_chan_ff < `EP_FIRST_PASS_CHAN;
wire recv_buffered = recv_chan_ff < `EP_FIRST_PASS_CHAN;

// bus address phase accepted
wire addr_ok = hsel_in & htrans_in[1] & hready_in;

// ***************************************
// register read mux
// ***************************************
// reserved bits read as zero
always @*
begin
	rd_word = 32'h0000_0000;
	case (rd_addr_ff)
		`EP_CTRL_OFS:
		begin
			rd_word[`EP_CTRL_SEND_EN_BIT] = send_en_ff;
			rd_word[`EP_CTRL_RECV_EN_BIT] = recv_en_ff;
			rd_word[`EP_CTRL_NORTH_BIT] = north_ff;
		end
		`EP_PLACE_OFS:
			rd_word[7:0] = {col_ff, row_ff};
		`EP_SEND_SEL_OFS:
			rd_word[12:0] = {send_chan_ff, 2'b00, send_mac_select_ff, send_rate_ff};
		`EP_RECV_SEL_OFS:
			rd_word[12:0] = {recv_chan_ff, 2'b00, recv_mac_select_ff, recv_rate_ff};
		`EP_SEND_MARK_OFS:
			rd_word = send_mark_ff;
		`EP_RECV_MARK_OFS:
			rd_word = recv_mark_ff;
		`EP_SOUTH_PRIO_OFS:
			rd_word = southbound_priority_pattern_ff;
		`EP_NORTH_PRIO_OFS:
			rd_word = northbound_priority_pattern_ff;
		`EP_STATUS_OFS:
			rd_word[9:0] = {recv_valid_ff, dn_valid_ff, recv_at_mark_ff, send_at_mark_ff};
		default:
			rd_word = 32'h0000_0000; // unmapped reads zero
	endcase
end

// ***************************************
// ahb-lite slave
// ***************************************
// reads take one wait state so that a write just before is seen
always @(posedge clk_in)
begin
	if (sys_rst_in)
	begin
		wr_pend_ff <= 1'b0;
		rd_pend_ff <= 1'b0;
		wr_addr_ff <= 8'h00;
		rd_addr_ff <= 8'h00;
		hrdata_ff <= 32'h0000_0000;
		hreadyout_ff <= 1'b1;
		hresp_ff <= 1'b0;
	end
	else
	begin
		hresp_ff <= 1'b0; // always okay
		if (rd_pend_ff)
		begin
			hrdata_ff <= rd_word;
			hreadyout_ff <= 1'b1;
			rd_pend_ff <= 1'b0;
			wr_pend_ff <= 1'b0;
		end
		else
		begin
			wr_pend_ff <= addr_ok & hwrite_in;
			rd_pend_ff <= addr_ok & ~hwrite_in;
			hreadyout_ff <= ~(addr_ok & ~hwrite_in);
			if (addr_ok)
			begin
				wr_addr_ff <= haddr_in[7:0];
				rd_addr_ff <= haddr_in[7:0];
			end
		end
	end
end

// ***************************************
// settings write and network state
// ***************************************
// sync reset only: the interface reset must leave this untouched
always @(posedge clk_in)
begin
	if (sys_rst_in)
	begin
		send_en_ff <= `EP_EN_RST;
		recv_en_ff <= `EP_EN_RST;
		north_ff <= 1'b0;
		row_ff <= `EP_ROW_RST;
		col_ff <= `EP_COL_RST;
		send_rate_ff <= `EP_RATE_RST;
		recv_rate_ff <= `EP_RATE_RST;
		send_mac_select_ff <= `EP_MAC_RST;
		recv_mac_select_ff <= `EP_MAC_RST;
		send_chan_ff <= `EP_CHAN_RST;
		recv_chan_ff <= `EP_CHAN_RST;
		send_mark_ff <= `EP_MARK_RST;
		recv_mark_ff <= `EP_MARK_RST;
		southbound_priority_pattern_ff <= `EP_PRIO_RST;
		northbound_priority_pattern_ff <= `EP_PRIO_RST;
	end
	else
	begin
		// rotate the active pattern after each contended cycle
		if (contend & ~north_ff)
			southbound_priority_pattern_ff <= {southbound_priority_pattern_ff[30:0],
				southbound_priority_pattern_ff[31]};
		if (contend & north_ff)
			northbound_priority_pattern_ff <= {northbound_priority_pattern_ff[30:0],
				northbound_priority_pattern_ff[31]};
		if (wr_pend_ff)
		begin
			case (wr_addr_ff)
				`EP_CTRL_OFS:
				begin
					send_en_ff <= hwdata_in[`EP_CTRL_SEND_EN_BIT];
					recv_en_ff <= hwdata_in[`EP_CTRL_RECV_EN_BIT];
					north_ff <= hwdata_in[`EP_CTRL_NORTH_BIT];
				end
				`EP_PLACE_OFS:
				begin
					// out-of-range placements are dropped, old value kept
					if (hwdata_in[3:0] >= `EP_ROW_MIN && hwdata_in[3:0] <= `EP_ROW_MAX)
						row_ff <= hwdata_in[3:0];
					if (hwdata_in[7:4] == `EP_COL_A || hwdata_in[7:4] == `EP_COL_B ||
						hwdata_in[7:4] == `EP_COL_C || hwdata_in[7:4] == `EP_COL_D)
						col_ff <= hwdata_in[7:4];
				end
				`EP_SEND_SEL_OFS:
				begin
					if (hwdata_in[3:0] <= `EP_RATE_MAX)
						send_rate_ff <= hwdata_in[3:0];
					send_mac_select_ff <= hwdata_in[5:4];
					send_chan_ff <= hwdata_in[12:8];
				end
				`EP_RECV_SEL_OFS:
				begin
					if (hwdata_in[3:0] <= `EP_RATE_MAX)
						recv_rate_ff <= hwdata_in[3:0];
					recv_mac_select_ff <= hwdata_in[5:4];
					recv_chan_ff <= hwdata_in[12:8];
				end
				`EP_SEND_MARK_OFS:
					send_mark_ff <= hwdata_in;
				`EP_RECV_MARK_OFS:
					recv_mark_ff <= hwdata_in;
				`EP_SOUTH_PRIO_OFS:
				begin
					// an all-ones pattern would starve upstream; ignore it
					if (hwdata_in != `EP_PRIO_BAD)
						southbound_priority_pattern_ff <= hwdata_in;
				end
				`EP_NORTH_PRIO_OFS:
				begin
					if (hwdata_in != `EP_PRIO_BAD)
						northbound_priority_pattern_ff <= hwdata_in;
				end
				default:
					north_ff <= north_ff; // unmapped writes ignored
			endcase
		end
	end
end

// ***************************************
// fifo level marks
// ***************************************
// one comparator per threshold byte
genvar g;
generate
	for (g = 0; g < 4; g = g + 1)
	begin : mark_gen
		always @(posedge clk_in)
		begin
			if (sys_rst_in)
			begin
				send_at_mark_ff[g] <= 1'b0;
				recv_at_mark_ff[g] <= 1'b0;
			end
			else
			begin
				send_at_mark_ff[g] <= send_buffered &
					({{(32-LEVEL_W){1'b0}}, send_level_in} > {24'h00_0000, send_mark_ff[8*g+7 -: 8]});
				recv_at_mark_ff[g] <= recv_buffered &
					({{(32-LEVEL_W){1'b0}}, recv_level_in} > {24'h00_0000, recv_mark_ff[8*g+7 -: 8]});
			end
		end
	end
endgenerate

// ***************************************
// fabric reset output
// ***************************************
always @(posedge clk_in)
begin
	fabric_rst_n_ff <= `EP_FABRIC_RST_LVL;
end

// ***************************************
// send merge and receive slot
// ***************************************
// async interface reset clears only handshake and slot state
always @(posedge clk_in or negedge intf_rst_n_in)
begin
	if (!intf_rst_n_in)
	begin
		send_accept_ff <= 1'b0;
		up_accept_ff <= 1'b0;
		dn_valid_ff <= 1'b0;
		dn_dest_ff <= {ID_W{1'b0}};
		dn_sop_ff <= 1'b0;
		dn_eop_ff <= 1'b0;
		dn_data_ff <= {DATA_W{1'b0}};
		net_accept_ff <= 1'b0;
		recv_valid_ff <= 1'b0;
		recv_src_ff <= {ID_W{1'b0}};
		recv_sop_ff <= 1'b0;
		recv_eop_ff <= 1'b0;
		recv_data_ff <= {DATA_W{1'b0}};
	end
	else if (sys_rst_in)
	begin
		send_accept_ff <= 1'b0;
		up_accept_ff <= 1'b0;
		dn_valid_ff <= 1'b0;
		net_accept_ff <= 1'b0;
		recv_valid_ff <= 1'b0;
	end
	else
	begin
		// accept for next cycle only if the slot will be empty
		send_accept_ff <= ~nxt_dn_valid & send_en_ff & grant_local;
		up_accept_ff <= ~nxt_dn_valid & ~grant_local;
		dn_valid_ff <= nxt_dn_valid;
		if (send_take)
		begin
			dn_dest_ff <= send_dest_in;
			dn_sop_ff <= send_sop_in;
			dn_eop_ff <= send_eop_in;
			dn_data_ff <= send_data_in;
		end
		else if (up_take)
		begin
			dn_dest_ff <= up_dest_in;
			dn_sop_ff <= up_sop_in;
			dn_eop_ff <= up_eop_in;
			dn_data_ff <= up_data_in;
		end
		net_accept_ff <= ~nxt_recv_valid & recv_en_ff;
		recv_valid_ff <= nxt_recv_valid;
		if (net_take)
		begin
			recv_src_ff <= net_src_in;
			recv_sop_ff <= net_sop_in;
			recv_eop_ff <= net_eop_in;
			recv_data_ff <= net_data_in;
		end
	end
end

// ***************************************
// outputs
// ***************************************
assign hrdata_out = hrdata_ff;
assign hreadyout_out = hreadyout_ff;
assign hresp_out = hresp_ff;
assign fabric_rst_n_out = fabric_rst_n_ff;
assign send_accept_out = send_accept_ff;
assign up_accept_out = up_accept_ff;
assign dn_offer_out = dn_valid_ff;
assign dn_dest_out = dn_dest_ff;
assign dn_sop_out = dn_sop_ff;
assign dn_eop_out = dn_eop_ff;
assign dn_data_out = dn_data_ff;
assign net_accept_out = net_accept_ff;
assign recv_offer_out = recv_valid_ff;
assign recv_src_out = recv_src_ff;
assign recv_sop_out = recv_sop_ff;
assign recv_eop_out = recv_eop_ff;
assign recv_data_out = recv_data_ff;
assign send_at_mark_out = send_at_mark_ff;
assign recv_at_mark_out = recv_at_mark_ff;

endmodule

// *** hw/net_endpoint_map.vh ***
// constants for the network access endpoint: register offsets, field
// positions, reset values and legal ranges of the settings.
// assumes inclusion by bare name from the endpoint design file.
`ifndef NET_ENDPOINT_MAP_VH
`define NET_ENDPOINT_MAP_VH

// ***************************************
// register byte offsets
// ***************************************
`define EP_CTRL_OFS 8'h00
`define EP_PLACE_OFS 8'h04
`define EP_SEND_SEL_OFS 8'h08
`define EP_RECV_SEL_OFS 8'h0C
`define EP_SEND_MARK_OFS 8'h10
`define EP_RECV_MARK_OFS 8'h14
`define EP_SOUTH_PRIO_OFS 8'h18
`define EP_NORTH_PRIO_OFS 8'h1C
`define EP_STATUS_OFS 8'h20

// ***************************************
// field positions
// ***************************************
`define EP_CTRL_SEND_EN_BIT 0
`define EP_CTRL_RECV_EN_BIT 1
`define EP_CTRL_NORTH_BIT 2
`define EP_ROW_LSB 0
`define EP_COL_LSB 4
`define EP_RATE_LSB 0
`define EP_MAC_LSB 4
`define EP_CHAN_LSB 8

// ***************************************
// reset values
// ***************************************
`define EP_EN_RST 1'b1
`define EP_ROW_RST 4'b1000
`define EP_COL_RST 4'b0100
`define EP_RATE_RST 4'b0100
`define EP_MAC_RST 2'b10
`define EP_CHAN_RST 5'b00000
`define EP_MARK_RST 32'haaaa_aaaa
`define EP_PRIO_RST 32'haaaa_aaaa
`define EP_FABRIC_RST_LVL 1'b0

// ***************************************
// legal ranges
// ***************************************
`define EP_ROW_MIN 4'b0001
`define EP_ROW_MAX 4'b1000
`define EP_COL_A 4'b0001
`define EP_COL_B 4'b0010
`define EP_COL_C 4'b0100
`define EP_COL_D 4'b0101
`define EP_RATE_MAX 4'b1000
`define EP_PRIO_BAD 32'hffff_ffff
`define EP_FIRST_PASS_CHAN 5'b1_0000

`endif

// *** tb/fabric_user_model.sv ***
// user-side sink for the endpoint's receive path.
// assumes the bench sets stall_in just after a clock edge.
`timescale 1ns/1ps
module fabric_user_model (
	input wire clk_in,
	input wire stall_in,
	input wire offer_in,
	input wire [3:0] src_in,
	input wire sop_in,
	input wire eop_in,
	input wire [292:0] data_in,
	output logic accept_out
);
	// words taken, oldest first, as source, flags, data
	logic [298:0] got [$];
	initial accept_out = 1'b0;
	// ready whenever not told to stall; a slow user just holds it low
	always @(posedge clk_in)
		accept_out <= !stall_in;
	// a word counts only on an edge with both offer and accept high
	always @(posedge clk_in)
		if (offer_in === 1'b1 && accept_out === 1'b1)
			got.push_back({src_in, sop_in, eop_in, data_in});
endmodule

// *** tb/net_endpoint_properties.sv ***
// checker for the network endpoint: forwarding, holding and bus timing.
// assumes it is bound to net_endpoint and sees only that module's ports.
`timescale 1ns/1ps
module net_endpoint_properties #(
	parameter DATA_W = 293,
	parameter ID_W = 4
) (
	input logic clk_in,
	input logic sys_rst_in,
	input logic intf_rst_n_in,
	input logic hsel_in,
	input logic [1:0] htrans_in,
	input logic hwrite_in,
	input logic hready_in,
	input logic hreadyout_out,
	input logic fabric_rst_n_out,
	input logic send_offer_in,
	input logic send_accept_out,
	input logic [ID_W-1:0] send_dest_in,
	input logic send_sop_in,
	input logic send_eop_in,
	input logic [DATA_W-1:0] send_data_in,
	input logic up_accept_out,
	input logic dn_offer_out,
	input logic dn_accept_in,
	input logic [ID_W-1:0] dn_dest_out,
	input logic dn_sop_out,
	input logic dn_eop_out,
	input logic [DATA_W-1:0] dn_data_out,
	input logic net_offer_in,
	input logic net_accept_out,
	input logic [ID_W-1:0] net_src_in,
	input logic [DATA_W-1:0] net_data_in,
	input logic recv_offer_out,
	input logic recv_accept_in,
	input logic [ID_W-1:0] recv_src_out,
	input logic [DATA_W-1:0] recv_data_out
);
	// ********
	// properties, all on the one clock
	// ********
	default clocking cb @(posedge clk_in);
	endclocking
	// either reset voids a transfer in flight
	default disable iff (sys_rst_in || !intf_rst_n_in);
	a_fabric_low:
	assert property (fabric_rst_n_out == 1'b0) else $error("fabric reset output not low");
	a_send_fwd:
	assert property (send_offer_in && send_accept_out |=> dn_offer_out && dn_data_out == $past(send_data_in)
		&& dn_dest_out == $past(send_dest_in) && {dn_sop_out, dn_eop_out} == $past({send_sop_in, send_eop_in}))
		else $error("sent word not forwarded");
	a_dn_hold:
	assert property (dn_offer_out && !dn_accept_in |=> dn_offer_out && $stable(dn_data_out) && $stable(dn_dest_out))
		else $error("network word dropped while stalled");
	a_slot_busy:
	assert property (send_offer_in && send_accept_out |=> !send_accept_out && !up_accept_out)
		else $error("accept while slot full");
	a_one_grant:
	assert property (!(send_accept_out && up_accept_out)) else $error("both sources accepted");
	a_recv_fwd:
	assert property (net_offer_in && net_accept_out |=> recv_offer_out && recv_src_out == $past(net_src_in)
		&& recv_data_out == $past(net_data_in)) else $error("received word not presented");
	a_recv_hold:
	assert property (recv_offer_out && !recv_accept_in |=> recv_offer_out && $stable(recv_data_out)
		&& $stable(recv_src_out)) else $error("received word changed while stalled");
	a_intf_clear:
	assert property (disable iff (sys_rst_in) !intf_rst_n_in |-> !send_accept_out && !recv_offer_out
		&& !dn_offer_out && !net_accept_out) else $error("interface not cleared");
	a_read_wait:
	assert property (hsel_in && htrans_in[1] && hready_in && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
		else $error("read wait cycle wrong");
	a_write_ready:
	assert property (hsel_in && htrans_in[1] && hready_in && hwrite_in |=> hreadyout_out)
		else $error("write stalled");
endmodule
bind net_endpoint net_endpoint_properties #(.DATA_W(DATA_W), .ID_W(ID_W)) u_props (.clk_in, .sys_rst_in,
	.intf_rst_n_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hreadyout_out, .fabric_rst_n_out,
	.send_offer_in, .send_accept_out, .send_dest_in, .send_sop_in, .send_eop_in, .send_data_in, .up_accept_out,
	.dn_offer_out, .dn_accept_in, .dn_dest_out, .dn_sop_out, .dn_eop_out, .dn_data_out, .net_offer_in,
	.net_accept_out, .net_src_in, .net_data_in, .recv_offer_out, .recv_accept_in, .recv_src_out, .recv_data_out);

// *** tb/tb_network_access_endpoint.sv ***
// bench for the network endpoint: settings bus, send, receive, merge, marks.
// assumes the checker is bound in and the partner sinks received words.
`timescale 1ns/1ps
`include "net_endpoint_map.vh"
module tb_network_access_endpoint;
	// ********
	// stimulus and observed signals
	// ********
	logic clk_in = 1'b0, sys_rst_in = 1'b1, intf_rst_n = 1'b0, stall = 1'b0, dn_acc = 1'b1, hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic s_off = 1'b0, u_off = 1'b0, n_off = 1'b0;
	logic [298:0] s_w = '0, u_w = '0, n_w = '0;
	logic [7:0] s_lvl = 8'h00, r_lvl = 8'h00;
	wire [31:0] hrdata;
	wire hready, hresp, fab_n, s_acc, u_acc, n_acc, r_off, r_acc, r_sop, r_eop, d_off, d_sop, d_eop;
	wire [3:0] r_src, d_dest, s_mark, r_mark;
	wire [292:0] r_data, d_data;
	wire [2:0] accs = {n_acc, u_acc, s_acc};
	int fails = 0, samples_checked = 0;
	logic [298:0] dnq [$];
	net_endpoint DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .intf_rst_n_in(intf_rst_n), .hsel_in(1'b1),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .fabric_rst_n_out(fab_n),
		.send_offer_in(s_off), .send_accept_out(s_acc), .send_dest_in(s_w[298:295]), .send_sop_in(s_w[294]),
		.send_eop_in(s_w[293]), .send_data_in(s_w[292:0]), .recv_offer_out(r_off), .recv_accept_in(r_acc),
		.recv_src_out(r_src), .recv_sop_out(r_sop), .recv_eop_out(r_eop), .recv_data_out(r_data),
		.up_offer_in(u_off), .up_accept_out(u_acc), .up_dest_in(u_w[298:295]), .up_sop_in(u_w[294]),
		.up_eop_in(u_w[293]), .up_data_in(u_w[292:0]), .dn_offer_out(d_off), .dn_accept_in(dn_acc),
		.dn_dest_out(d_dest), .dn_sop_out(d_sop), .dn_eop_out(d_eop), .dn_data_out(d_data),
		.net_offer_in(n_off), .net_accept_out(n_acc), .net_src_in(n_w[298:295]), .net_sop_in(n_w[294]),
		.net_eop_in(n_w[293]), .net_data_in(n_w[292:0]), .send_level_in(s_lvl), .recv_level_in(r_lvl),
		.send_at_mark_out(s_mark), .recv_at_mark_out(r_mark));
	fabric_user_model partner (.clk_in(clk_in), .stall_in(stall), .offer_in(r_off), .src_in(r_src),
		.sop_in(r_sop), .eop_in(r_eop), .data_in(r_data), .accept_out(r_acc));
	initial
		forever #20 clk_in = ~clk_in;
	// log every word the network side takes
	always @(posedge clk_in)
		if (d_off === 1'b1 && dn_acc === 1'b1)
			dnq.push_back({d_dest, d_sop, d_eop, d_data});
	// ********
	// shared tasks
	// ********
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_word(input string what, input logic [298:0] exp, input logic [298:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one single bus transfer; waits on hready, never on a fixed count
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge clk_in);
		while (hready !== 1'b1)
			@(posedge clk_in);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk_in);
		while (hready !== 1'b1)
			@(posedge clk_in);
		r = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask
	task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk(what, exp, r);
	endtask
	// word with its flags taken from the low bits of the index
	function automatic logic [298:0] mk(input logic [3:0] id, input logic [7:0] i);
		logic [319:0] t;
		t = {10{24'hc3_5a96, i}};
		return {id, i[0], i[1], t[292:0]};
	endfunction
	// offer on send (0), upstream (1) or network (2); keep leaves offer up for a follow-on word
	task automatic push(input int p, input logic [298:0] w, input bit keep);
		case (p)
			0: {s_off, s_w} <= {1'b1, w};
			1: {u_off, u_w} <= {1'b1, w};
			default: {n_off, n_w} <= {1'b1, w};
		endcase
		@(posedge clk_in);
		while (accs[p] !== 1'b1)
			@(posedge clk_in);
		// released lines show the inverse, so stale data never looks valid
		if (!keep)
			case (p)
				0: {s_off, s_w} <= {1'b0, ~w};
				1: {u_off, u_w} <= {1'b0, ~w};
				default: {n_off, n_w} <= {1'b0, ~w};
			endcase
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_regs;
		int i;
		for (i = 0; i < 8; i++)
			rd_chk("reset value", 32'(i * 4), i > 3 ? `EP_MARK_RST : i == 0 ? 32'h3 : i == 1 ? 32'h48 : 32'h24);
		rd_chk("status idle", `EP_STATUS_OFS, 32'h0000_0000);
		wr(32'h0000_0040, 32'h1234_5678);
		rd_chk("unmapped", 32'h0000_0040, 32'h0000_0000);
		for (i = 1; i < 9; i++)
		begin
			wr(`EP_PLACE_OFS, 32'(i + 64));
			rd_chk("row", `EP_PLACE_OFS, 32'(i + 64));
		end
		for (i = 0; i < 6; i++)
		begin
			wr(`EP_PLACE_OFS, i < 3 ? 32'(24 + i * 16 + i / 2 * 16) : 32'(56 + (i - 3) * 33 - (i / 5) * 50));
			rd_chk("column", `EP_PLACE_OFS, i < 3 ? 32'(24 + i * 16 + i / 2 * 16) : i == 4 ? 32'h58 : 32'h48);
		end
		for (i = 0; i < 10; i++)
		begin
			wr(`EP_RECV_SEL_OFS, 32'(i + (i % 4) * 16 + 1280));
			rd_chk("rate and mac", `EP_RECV_SEL_OFS, i < 9 ? 32'(i + (i % 4) * 16 + 1280) : 32'h518);
		end
		wr(`EP_SEND_SEL_OFS, 32'h0000_1f38);
		rd_chk("send channel", `EP_SEND_SEL_OFS, 32'h0000_1f38);
		wr(`EP_SOUTH_PRIO_OFS, `EP_PRIO_BAD);
		rd_chk("bad pattern kept", `EP_SOUTH_PRIO_OFS, `EP_PRIO_RST);
		chk("bus response", 32'h0, hresp);
	endtask
	task automatic t_send;
		logic [298:0] a, b;
		a = mk(4'h3, 8'h01);
		b = mk(4'hf, 8'h02);
		dn_acc <= 1'b0;
		fork
			begin
				push(0, a, 1);
				push(0, b, 0);
			end
			begin
				repeat (6) @(posedge clk_in);
				dn_acc <= 1'b1;
			end
		join
		repeat (4) @(posedge clk_in);
		chk("merged count", 32'd2, dnq.size());
		chk_word("first sent word", a, dnq.pop_front());
		chk_word("second sent word", b, dnq.pop_front());
		wr(`EP_CTRL_OFS, 32'h0000_0000);
		repeat (2) @(posedge clk_in);
		chk("send accept disabled", 32'h0, s_acc);
		chk("net accept disabled", 32'h0, n_acc);
		wr(`EP_CTRL_OFS, 32'h0000_0003);
	endtask
	task automatic t_recv;
		logic [298:0] w;
		w = mk(4'h6, 8'h03);
		stall <= 1'b1;
		push(2, w, 0);
		repeat (5) @(posedge clk_in);
		chk("offer held", 32'h1, r_off);
		stall <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk("received count", 32'd1, partner.got.size());
		chk_word("received word", w, partner.got.pop_front());
	endtask
	task automatic t_arb;
		logic [298:0] l, u, f;
		int k;
		for (k = 1; k < 4; k++)
		begin
			l = mk(4'h2, 8'(k));
			u = mk(4'h9, 8'(k + 8));
			f = mk(4'h5, 8'(k + 16));
			// third pass swaps in the other direction's pattern
			if (k == 3)
			begin
				wr(`EP_NORTH_PRIO_OFS, 32'h0000_0001);
				wr(`EP_CTRL_OFS, 32'h0000_0007);
			end
			else
				wr(`EP_SOUTH_PRIO_OFS, 32'(k));
			// a filler word stalls in the slot so both offers really wait and contend
			dn_acc <= 1'b0;
			push(1, f, 1);
			fork
				push(0, l, 0);
				push(1, u, 0);
				begin
					repeat (4) @(posedge clk_in);
					dn_acc <= 1'b1;
				end
			join
			repeat (4) @(posedge clk_in);
			chk_word("filler word", f, dnq.pop_front());
			chk_word("first winner", k == 2 ? u : l, dnq.pop_front());
			chk_word("second winner", k == 2 ? l : u, dnq.pop_front());
		end
		wr(`EP_CTRL_OFS, 32'h0000_0003);
	endtask
	task automatic t_marks;
		wr(`EP_SEND_MARK_OFS, 32'h4030_2010);
		wr(`EP_RECV_MARK_OFS, 32'h00fe_ff01);
		wr(`EP_SEND_SEL_OFS, 32'h0000_0024);
		s_lvl <= 8'h30;
		r_lvl <= 8'hff;
		repeat (3) @(posedge clk_in);
		chk("send marks", 32'h3, s_mark);
		chk("recv marks", 32'hd, r_mark);
		rd_chk("status marks", `EP_STATUS_OFS, 32'h0000_00d3);
		wr(`EP_SEND_SEL_OFS, 32'h0000_1024);
		repeat (3) @(posedge clk_in);
		chk("pass-through marks", 32'h0, s_mark);
		chk("buffered marks", 32'hd, r_mark);
	endtask
	task automatic t_intf;
		stall <= 1'b1;
		push(2, mk(4'h1, 8'h05), 0);
		@(posedge clk_in);
		// clear lands just after an edge and is looked at before the next, so it needs no clock
		intf_rst_n <= 1'b0;
		#1 chk("offer cleared", 32'h0, r_off);
		chk("accept cleared", 32'h0, s_acc);
		@(posedge clk_in);
		intf_rst_n <= 1'b1;
		stall <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk("words after clear", 32'd0, partner.got.size());
		rd_chk("settings kept", `EP_PLACE_OFS, 32'h0000_0048);
		chk("fabric reset", 32'h0, fab_n);
	endtask
	task automatic finish_test;
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		intf_rst_n <= 1'b1;
		@(posedge clk_in);
		t_regs;
		t_send;
		t_recv;
		t_arb;
		t_marks;
		t_intf;
		finish_test;
	end
	// watchdog well beyond the few hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clk_in);
		fails++;
		finish_test;
	end
endmodule
